// *** core/undervolt_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module undervolt_ctrl (
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_por, // Reset in progress is power-on
  input wire undervolt_pkg::avs_req_type i_avs, // Avalon request
  output logic [31:0] o_avs_readdata, // Avalon read data
  output logic o_avs_waitrequest, // Avalon wait
  input wire logic i_undervolt_detect_en, // Detection circuit enabled
  input wire logic i_undervolt_detect, // Detect comparator tripped
  input wire logic i_undervolt_warning, // Warning comparator tripped
  input wire logic i_below_rearm, // Supply below rearm_threshold
  input wire logic i_stop_req, // CPU requests stop
  input wire logic i_wake_req, // Pending interrupt or reset
  output logic o_detect_irq, // Detect interrupt request
  output logic o_reset_req, // System reset request
  output logic o_irq, // Detect interrupt or masked event interrupt
  output var undervolt_pkg::stop_state_type o_stop_mode, // Current stop mode
  output logic o_pin_hold // Pin states latched
);
  import undervolt_pkg::*;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;

  logic take;
  logic wr;
  logic [7:0] wbyte;
  logic wake_ok;

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input ctrl_state_type s, input logic [2:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      ADDR_DETECT_CTRL: begin
        d[BIT_DETECT_FLAG] = s.detect_flag;
        d[BIT_DETECT_IRQ_EN] = s.detect_irq_en;
        d[BIT_SAFE] = s.safe;
        d[BIT_RESET_EN] = s.reset_en;
      end
      ADDR_WARN_PD_CTRL: begin
        d[BIT_WARN_FLAG] = s.warn_flag;
        d[BIT_PD_FLAG] = s.pd_flag;
        d[BIT_PD_ALLOW] = s.pd_allow;
        d[BIT_PD_SELECT] = s.pd_select;
      end
      ADDR_IRQ_STATUS: begin
        d[EVT_COUNT-1:0] = s.irq_status;
      end
      ADDR_IRQ_MASK: begin
        d[EVT_COUNT-1:0] = s.irq_mask;
      end
      default: begin
        d = 32'h0;
      end
    endcase
    return d;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    take = (i_avs.read | i_avs.write) & ~st_r.ack;
    wr = i_avs.write & st_r.ack & i_avs.byteenable[0];
    wbyte = i_avs.writedata[7:0];
    // Wake is suppressed while below rearm with safe set so a sagging supply cannot bounce
    wake_ok = i_wake_req & ~(st_r.safe & i_below_rearm);

    // One wait state: readdata is captured in the first cycle
    st_nxt.ack = take;
    if (take && i_avs.read) begin
      st_nxt.readdata = read_word(st_r, i_avs.address);
    end

    // Software writes
    if (wr) begin
      unique case (i_avs.address)
        ADDR_DETECT_CTRL: begin
          if (wbyte[BIT_DETECT_ACK]) begin
            st_nxt.detect_flag = 1'b0;
          end
          st_nxt.detect_irq_en = wbyte[BIT_DETECT_IRQ_EN];
          st_nxt.safe = wbyte[BIT_SAFE];
          if (!st_r.reset_en_locked) begin
            st_nxt.reset_en = wbyte[BIT_RESET_EN];
            st_nxt.reset_en_locked = 1'b1;
          end
        end
        ADDR_WARN_PD_CTRL: begin
          if (wbyte[BIT_WARN_ACK] && !i_undervolt_warning) begin
            st_nxt.warn_flag = 1'b0;
          end
          if (wbyte[BIT_PD_ACK]) begin
            st_nxt.pd_flag = 1'b0;
            st_nxt.pin_hold = 1'b0;
          end
          if (!st_r.pd_locked) begin
            st_nxt.pd_allow = wbyte[BIT_PD_ALLOW];
            st_nxt.pd_select = wbyte[BIT_PD_SELECT];
            st_nxt.pd_locked = 1'b1;
          end
        end
        ADDR_IRQ_STATUS: begin
          st_nxt.irq_status = st_r.irq_status & ~wbyte[EVT_COUNT-1:0];
        end
        ADDR_IRQ_MASK: begin
          st_nxt.irq_mask = wbyte[EVT_COUNT-1:0];
        end
        default: begin
          st_nxt.irq_mask = st_r.irq_mask;
        end
      endcase
    end

    // Hardware sets come after the writes so a set wins over a clear
    if (i_undervolt_detect_en && i_undervolt_detect) begin
      st_nxt.detect_flag = 1'b1;
      if (!st_r.detect_flag) begin
        st_nxt.irq_status[EVT_DETECT] = 1'b1;
      end
    end
    // Level sensitive, so a supply already low at reset sets it at once
    if (i_undervolt_warning) begin
      st_nxt.warn_flag = 1'b1;
      if (!st_r.warn_flag) begin
        st_nxt.irq_status[EVT_WARN] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Stop mode sequencing
    // ----------------------------------------------------------------
    unique case (st_r.stop_state)
      ST_RUN: begin
        if (i_stop_req) begin
          if (!st_r.pd_allow) begin
            st_nxt.stop_state = ST_STOP_POWERED;
          end else if (st_r.pd_select) begin
            st_nxt.stop_state = ST_STOP_PARTIAL;
          end else begin
            st_nxt.stop_state = ST_STOP_FULL;
          end
        end
      end
      ST_STOP_POWERED: begin
        if (wake_ok) begin
          st_nxt.stop_state = ST_RUN;
        end
      end
      ST_STOP_FULL: begin
        if (wake_ok) begin
          st_nxt.stop_state = ST_RUN;
        end
      end
      ST_STOP_PARTIAL: begin
        // Pins freeze on entry so outputs survive the register power-down
        st_nxt.pin_hold = 1'b1;
        if (wake_ok) begin
          st_nxt.stop_state = ST_RUN;
          st_nxt.pd_flag = 1'b1;
          st_nxt.irq_status[EVT_PD_RECOVER] = 1'b1;
        end
      end
    endcase

    // ----------------------------------------------------------------
    // Reset
    // ----------------------------------------------------------------
    if (!i_rst_n) begin
      st_nxt.ack = 1'b0;
      st_nxt.readdata = 32'h0;
      st_nxt.detect_flag = 1'b0;
      st_nxt.detect_irq_en = 1'b0;
      st_nxt.safe = 1'b0;
      st_nxt.reset_en_locked = 1'b0;
      // Only power-on restores it, so a detect reset cannot disarm itself
      st_nxt.reset_en = i_por ? RST_RESET_EN_POR : st_r.reset_en;
      st_nxt.warn_flag = 1'b0;
      st_nxt.pd_flag = 1'b0;
      st_nxt.pd_allow = 1'b0;
      st_nxt.pd_select = 1'b0;
      st_nxt.pd_locked = 1'b0;
      st_nxt.pin_hold = 1'b0;
      st_nxt.stop_state = ST_RUN;
      st_nxt.irq_status = RST_IRQ_MASK;
      st_nxt.irq_mask = RST_IRQ_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~st_r.ack;
  assign o_avs_readdata = st_r.readdata;
  assign o_detect_irq = st_r.detect_irq_en & st_r.detect_flag;
  assign o_reset_req = st_r.reset_en & st_r.detect_flag;
  assign o_irq = o_detect_irq | (|(st_r.irq_status & st_r.irq_mask));
  assign o_stop_mode = st_r.stop_state;
  assign o_pin_hold = st_r.pin_hold;

endmodule : undervolt_ctrl
`default_nettype wire

// *** core/undervolt_pkg.sv ***
package undervolt_pkg;

  // ----------------------------------------------------------------
  // Register map, word index on the Avalon address
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DETECT_CTRL = 3'h0;
  localparam logic [2:0] ADDR_WARN_PD_CTRL = 3'h1;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DETECT_FLAG = 7;
  localparam int BIT_DETECT_ACK = 6;
  localparam int BIT_DETECT_IRQ_EN = 5;
  localparam int BIT_SAFE = 4;
  localparam int BIT_RESET_EN = 3;
  localparam int BIT_WARN_FLAG = 7;
  localparam int BIT_WARN_ACK = 6;
  localparam int BIT_PD_FLAG = 3;
  localparam int BIT_PD_ACK = 2;
  localparam int BIT_PD_ALLOW = 1;
  localparam int BIT_PD_SELECT = 0;
  localparam int EVT_DETECT = 0;
  localparam int EVT_WARN = 1;
  localparam int EVT_PD_RECOVER = 2;
  localparam int EVT_COUNT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_RESET_EN_POR = 1'b1;
  localparam logic [EVT_COUNT-1:0] RST_IRQ_MASK = 3'h0;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP_POWERED = 2'b01,
    ST_STOP_FULL = 2'b10,
    ST_STOP_PARTIAL = 2'b11
  } stop_state_type;

  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] readdata;
    logic detect_flag;
    logic detect_irq_en;
    logic safe;
    logic reset_en;
    logic reset_en_locked;
    logic warn_flag;
    logic pd_flag;
    logic pd_allow;
    logic pd_select;
    logic pd_locked;
    logic pin_hold;
    stop_state_type stop_state;
    logic [EVT_COUNT-1:0] irq_status;
    logic [EVT_COUNT-1:0] irq_mask;
  } ctrl_state_type;

endpackage : undervolt_pkg

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import undervolt_pkg::*;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_por = 1'h1, i_stop_req = 1'h0, i_wake_req = 1'h0;
  logic i_undervolt_detect_en = 1'h0, i_undervolt_detect = 1'h0;
  logic i_undervolt_warning = 1'h0, i_below_rearm = 1'h0;
  logic o_avs_waitrequest, o_detect_irq, o_reset_req, o_irq, o_pin_hold;
  logic [31:0] o_avs_readdata;
  logic [31:0] lfsr = 32'h20BF;
  avs_req_type i_avs = '0;
  stop_state_type o_stop_mode;
  int n_errors = 0, checks = 0;
  always #12.5 i_clk = ~i_clk;
  undervolt_ctrl undervolt_ctrl_inst (.*);
  // ------------------------------
  // Bus cycles and comparisons
  // ------------------------------
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  task automatic final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Reads compare with d; random upper data must be ignored
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int k;
    @(posedge i_clk);
    lfsr = step(lfsr);
    i_avs <= '{a, !wr, wr, {lfsr[23:0], d}, 4'hF};
    for (k = 0; k < 9; k++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'h0)
        break;
    end
    i_avs.read <= 1'h0;
    i_avs.write <= 1'h0;
    if (k == 9) begin
      n_errors++;
      final_report();
    end else if (!wr)
      cmp(o_avs_readdata, {24'h0, d});
  endtask : bus
  // Stop or wake request, mode checked once it has landed
  task automatic go(input logic w, input stop_state_type e);
    @(posedge i_clk);
    i_stop_req <= !w;
    i_wake_req <= w;
    repeat (2) @(posedge i_clk);
    i_stop_req <= 1'h0;
    i_wake_req <= 1'h0;
    cmp({30'h0, o_stop_mode}, {30'h0, e});
  endtask : go
  task automatic det;
    @(posedge i_clk);
    i_undervolt_detect <= 1'h1;
    @(posedge i_clk);
    i_undervolt_detect <= 1'h0;
  endtask : det
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    i_undervolt_detect_en <= 1'h1;
    bus(1'h0, ADDR_DETECT_CTRL, 8'h08);
    det();
    bus(1'h0, ADDR_DETECT_CTRL, 8'h88);
    cmp({31'h0, o_reset_req}, 32'h1);
    bus(1'h1, ADDR_DETECT_CTRL, 8'h60);
    bus(1'h1, ADDR_DETECT_CTRL, 8'h38);
    det();
    bus(1'h0, ADDR_DETECT_CTRL, 8'hB0);
    cmp({30'h0, o_detect_irq, o_reset_req}, 32'h2);
    bus(1'h1, ADDR_DETECT_CTRL, 8'h70);
    bus(1'h0, ADDR_DETECT_CTRL, 8'h30);
    i_undervolt_warning <= 1'h1;
    bus(1'h1, ADDR_WARN_PD_CTRL, 8'h43);
    bus(1'h0, ADDR_WARN_PD_CTRL, 8'h83);
    i_undervolt_warning <= 1'h0;
    bus(1'h0, ADDR_WARN_PD_CTRL, 8'h83);
    bus(1'h1, ADDR_WARN_PD_CTRL, 8'h40);
    bus(1'h0, ADDR_WARN_PD_CTRL, 8'h03);
    bus(1'h0, ADDR_IRQ_STATUS, 8'h03);
    bus(1'h1, ADDR_IRQ_STATUS, 8'h03);
    bus(1'h1, ADDR_IRQ_MASK, 8'h04);
    bus(1'h0, ADDR_IRQ_STATUS, 8'h00);
    bus(1'h0, 3'h5, 8'h00);
    i_below_rearm <= 1'h1;
    go(1'h0, ST_STOP_PARTIAL);
    go(1'h1, ST_STOP_PARTIAL);
    cmp({31'h0, o_pin_hold}, 32'h1);
    i_below_rearm <= 1'h0;
    go(1'h1, ST_RUN);
    bus(1'h0, ADDR_WARN_PD_CTRL, 8'h0B);
    cmp({30'h0, o_pin_hold, o_irq}, 32'h3);
    bus(1'h1, ADDR_WARN_PD_CTRL, 8'h04);
    bus(1'h0, ADDR_WARN_PD_CTRL, 8'h03);
    bus(1'h1, ADDR_IRQ_STATUS, 8'h04);
    @(posedge i_clk);
    cmp({30'h0, o_pin_hold, o_irq}, 32'h0);
    // Warm reset must keep the detect reset enable as last written
    i_por <= 1'h0;
    i_rst_n <= 1'h0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    bus(1'h0, ADDR_DETECT_CTRL, 8'h00);
    go(1'h0, ST_STOP_POWERED);
    go(1'h1, ST_RUN);
    bus(1'h1, ADDR_WARN_PD_CTRL, 8'h02);
    go(1'h0, ST_STOP_FULL);
    go(1'h1, ST_RUN);
    final_report();
  end
endmodule : tb
bind undervolt_ctrl undervolt_ctrl_assertions undervolt_ctrl_assertions_inst (.*);
`default_nettype wire

// *** verif/undervolt_ctrl_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module undervolt_ctrl_assertions
  import undervolt_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset
  input wire undervolt_pkg::avs_req_type i_avs, // bus
  input wire logic [31:0] o_avs_readdata, // data
  input wire logic o_avs_waitrequest, // wait
  input wire logic i_undervolt_detect_en, // enable
  input wire logic i_undervolt_detect, // detect
  input wire logic i_stop_req, // stop
  input wire logic i_wake_req, // wake
  input wire logic o_detect_irq, // irq
  input wire logic o_reset_req, // reset
  input wire logic o_irq, // irq
  input wire undervolt_pkg::stop_state_type o_stop_mode, // mode
  input wire logic o_pin_hold // hold
);
  // ------------------------------
  // Properties
  // ------------------------------
  logic rack0, rack1, trip;
  assign rack0 = i_avs.read && !o_avs_waitrequest && i_avs.address == ADDR_DETECT_CTRL;
  assign rack1 = i_avs.read && !o_avs_waitrequest && i_avs.address == ADDR_WARN_PD_CTRL;
  assign trip = i_undervolt_detect && i_undervolt_detect_en;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_DACK_ZERO: assert property (rack0 |-> !o_avs_readdata[6])
    else $error("detect ack read high");
  AST_PACK_ZERO: assert property (rack1 |-> !o_avs_readdata[6] && !o_avs_readdata[2])
    else $error("ack bits read high");
  AST_IRQ_REQ: assert property (o_detect_irq |-> o_irq)
    else $error("detect irq not on irq line");
  AST_RST_CAUSE: assert property ($rose(o_reset_req) |-> $past(trip))
    else $error("reset request without detect");
  AST_STOP_GO: assert property (o_stop_mode == ST_RUN && i_stop_req |=> o_stop_mode != ST_RUN)
    else $error("stop request ignored");
  AST_NO_WAKE: assert property (o_stop_mode != ST_RUN && !i_wake_req |=> $stable(o_stop_mode))
    else $error("stop left without wake");
  AST_HOLD_RISE: assert property ($rose(o_pin_hold) |-> $past(o_stop_mode) == ST_STOP_PARTIAL)
    else $error("pin hold outside partial stop");
  AST_HOLD_KEEP: assert property (o_pin_hold && !(i_avs.write && !o_avs_waitrequest) |=> o_pin_hold)
    else $error("pin hold dropped without write");
  cover property (o_stop_mode == ST_STOP_PARTIAL && i_wake_req);
  cover property (o_reset_req);
  cover property (o_irq && !o_detect_irq);
endmodule : undervolt_ctrl_assertions
`default_nettype wire
